// >>> rate_fifo_pkg.sv
// constants, register map and types for the rate sample buffer
package rate_fifo_pkg;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL       = 8'h00;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h04;
   localparam logic [7:0] ADDR_SYNC_COUNT = 8'h08;
   localparam logic [7:0] ADDR_STATUS     = 8'h0c;
   localparam logic [7:0] ADDR_DATA_X     = 8'h10;
   localparam logic [7:0] ADDR_DATA_Y     = 8'h14;
   localparam logic [7:0] ADDR_DATA_Z     = 8'h18;
   localparam logic [7:0] ADDR_DATA_TEMP  = 8'h1c;
   localparam logic [7:0] ADDR_FIFO_XY    = 8'h20;
   localparam logic [7:0] ADDR_FIFO_Z     = 8'h24;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int CTRL_MODE_LSB    = 0;
   localparam int CTRL_OVERRUN     = 2;
   localparam int CTRL_SYNC_HIGH   = 3;
   localparam int CTRL_SYNC_LEVEL  = 4;
   localparam int CTRL_CAPTURE     = 5;
   localparam int CTRL_MAP         = 6;
   localparam int CTRL_WAKE        = 7;
   localparam int CTRL_AXIS_LSB    = 8;
   localparam logic [10:0] CTRL_RESET = 11'h700;

   // ----------------------------------------------------------------
   // status bits; the low four are also the interrupt sources
   // ----------------------------------------------------------------
   localparam int ST_FULL     = 0;
   localparam int ST_OVERRUN  = 1;
   localparam int ST_SYNC     = 2;
   localparam int ST_NONEMPTY = 3;
   localparam int ST_COUNT_LSB = 8;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      MODE_OFF       = 2'b00,
      MODE_NORMAL    = 2'b01,
      MODE_INTERRUPT = 2'b10,
      MODE_SNAPSHOT  = 2'b11
   } fifo_mode_t;
endpackage

// >>> rate_sample_fifo_sync.sv
// sample buffer, capture control and sync handling with an axi4-lite slave
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
module rate_sample_fifo_sync #(
   parameter int DEPTH = 256,
   parameter int AW    = 8
) (
   // clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset,
   // measurement path
   input  wire logic        i_sample_valid,
   input  wire logic [15:0] i_rate_x,
   input  wire logic [15:0] i_rate_y,
   input  wire logic [15:0] i_rate_z,
   input  wire logic [15:0] i_temp,
   input  wire logic        i_rate_irq,
   // sync pin and power state
   input  wire logic        i_sync_input_pin,
   input  wire logic        i_low_power,
   output logic             o_wake_request,
   // interrupt lines
   output logic             o_irq_line_a,
   output logic             o_irq_line_b,
   // axi4-lite write address
   input  wire logic [7:0]  i_s_axi_awaddr,
   input  wire logic        i_s_axi_awvalid,
   output logic             o_s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] i_s_axi_wdata,
   input  wire logic [3:0]  i_s_axi_wstrb,
   input  wire logic        i_s_axi_wvalid,
   output logic             o_s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       o_s_axi_bresp,
   output logic             o_s_axi_bvalid,
   input  wire logic        i_s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]  i_s_axi_araddr,
   input  wire logic        i_s_axi_arvalid,
   output logic             o_s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      o_s_axi_rdata,
   output logic [1:0]       o_s_axi_rresp,
   output logic             o_s_axi_rvalid,
   input  wire logic        i_s_axi_rready
);
   import rate_fifo_pkg::*;
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [47:0]   mem [DEPTH];
   logic [10:0]   ctrl_reg;
   logic [7:0]    irq_en_reg, sync_count_reg, capture_left_reg, aw_addr_reg;
   logic [15:0]   data_reg [4];
   logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
   logic [AW:0]   count_reg;
   logic          lock_reg, armed_reg, snap_trig_reg, sync_prev_reg;
   logic          overrun_flag_reg, sync_flag_reg, aw_held_reg, w_held_reg;
   logic [31:0]   w_data_reg;
   logic [3:0]    w_strb_reg, sources;
   fifo_mode_t    mode;
   logic          sync_active, sync_edge, sync_event, gate_open, take_sample;
   logic          buf_enabled, ovr_effective, full, push, overwrite, pop;
   logic          do_write, do_read, status_clear;
   logic [47:0]   sample_set;
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a <= ADDR_FIFO_Z) && (a[1:0] == 2'b00);
   endfunction
   // ----------------------------------------------------------------
   // sync input detection
   // ----------------------------------------------------------------
   assign mode        = fifo_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
   assign sync_active = i_sync_input_pin == ctrl_reg[CTRL_SYNC_HIGH];
   assign sync_edge   = sync_active && !sync_prev_reg;
   assign sync_event  = ctrl_reg[CTRL_SYNC_LEVEL] ? sync_active
                                                  : sync_edge;
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         sync_prev_reg <= 1'b1; // no false edge from an active idle pin
      end else begin
         sync_prev_reg <= sync_active;
      end
   end
   // the wake request follows sync_event one cycle late, only while in low power with the wake bit set
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_wake_request <= 1'b0;
      end else begin
         o_wake_request <= i_low_power && ctrl_reg[CTRL_WAKE]
                           && sync_event;
      end
   end
   // ----------------------------------------------------------------
   // capture gating: data is held off until the active edge
   // ----------------------------------------------------------------
   assign gate_open   = !ctrl_reg[CTRL_CAPTURE] || capture_left_reg != 8'h00;
   assign take_sample = i_sample_valid && gate_open;
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         capture_left_reg <= 8'h00;
      end else if (!ctrl_reg[CTRL_CAPTURE]) begin
         capture_left_reg <= 8'h00;
      end else if (capture_left_reg == 8'h00) begin
         // an edge landing on the last sample is ignored; edge only rearms
         if (sync_edge) begin
            capture_left_reg <= sync_count_reg;
         end
      end else if (i_sample_valid) begin
         capture_left_reg <= capture_left_reg - 8'h01;
      end
   end
   // ----------------------------------------------------------------
   // sample set with optional sync tag in the lsb
   // ----------------------------------------------------------------
   always_comb begin
      sample_set = {i_rate_z, i_rate_y, i_rate_x};
      for (int k = 0; k < 3; k++) begin
         if (ctrl_reg[CTRL_MAP] && ctrl_reg[CTRL_AXIS_LSB + k]) begin
            sample_set[16*k] = i_sync_input_pin;
         end
      end
   end
   // data registers always follow the newest accepted sample
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         for (int k = 0; k < 4; k++) begin
            data_reg[k] <= 16'h0000;
         end
      end else if (take_sample) begin
         data_reg[0] <= sample_set[15:0];
         data_reg[1] <= sample_set[31:16];
         data_reg[2] <= sample_set[47:32];
         data_reg[3] <= i_temp;
      end
   end

   // ----------------------------------------------------------------
   // mode sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_reset || do_write && aw_addr_reg == ADDR_CTRL) begin
         armed_reg     <= 1'b0;
         snap_trig_reg <= 1'b0;
      end else begin
         if (mode == MODE_INTERRUPT && i_rate_irq) begin
            armed_reg <= 1'b1;
         end
         if (mode == MODE_SNAPSHOT && i_rate_irq) begin
            snap_trig_reg <= 1'b1;
         end
      end
   end
   always_comb begin
      case (mode)
         MODE_NORMAL: begin
            buf_enabled   = 1'b1;
            ovr_effective = ctrl_reg[CTRL_OVERRUN];
         end
         MODE_INTERRUPT: begin
            buf_enabled   = armed_reg;
            ovr_effective = ctrl_reg[CTRL_OVERRUN];
         end
         MODE_SNAPSHOT: begin
            buf_enabled   = 1'b1;
            ovr_effective = !snap_trig_reg;
         end
         default: begin
            buf_enabled   = 1'b0;
            ovr_effective = 1'b0;
         end
      endcase
   end
   // ----------------------------------------------------------------
   // buffer storage and pointers
   // ----------------------------------------------------------------
   assign full      = count_reg == (AW+1)'(DEPTH);
   assign push      = take_sample && buf_enabled && !lock_reg
                      && (!full || ovr_effective);
   assign overwrite = push && full;
   assign pop       = do_read && o_s_axi_arready
                      && i_s_axi_araddr == ADDR_FIFO_Z
                      && mode != MODE_OFF && count_reg != '0;
   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= sample_set;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_reset || mode == MODE_OFF) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else if (overwrite) begin
         // oldest slot is lost, the rest stays readable in order
         wr_ptr_reg <= wr_ptr_reg + AW'(1);
         rd_ptr_reg <= wr_ptr_reg + AW'(1);
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + AW'(1);
         end
         if (push && !pop) begin
            count_reg <= count_reg + (AW+1)'(1);
         end else if (pop && !push) begin
            count_reg <= count_reg - (AW+1)'(1);
         end
      end
   end
   // once full without overrun, writing waits for a complete drain
   always_ff @(posedge i_sys_clk) begin
      if (i_reset || mode == MODE_OFF) begin
         lock_reg <= 1'b0;
      end else if (full && !ovr_effective) begin
         lock_reg <= 1'b1;
      end else if (count_reg == '0) begin
         lock_reg <= 1'b0;
      end
   end
   // ----------------------------------------------------------------
   // sticky status flags; a new event beats a clear in the same cycle
   // ----------------------------------------------------------------
   assign status_clear = do_write && aw_addr_reg == ADDR_STATUS;
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         overrun_flag_reg <= 1'b0;
         sync_flag_reg    <= 1'b0;
      end else begin
         if (overwrite || take_sample && buf_enabled && !push) begin
            overrun_flag_reg <= 1'b1;
         end else if (status_clear && w_data_reg[ST_OVERRUN]) begin
            overrun_flag_reg <= 1'b0;
         end
         if (sync_event) begin
            sync_flag_reg <= 1'b1;
         end else if (status_clear && w_data_reg[ST_SYNC]) begin
            sync_flag_reg <= 1'b0;
         end
      end
   end
   assign sources = {count_reg != '0, sync_flag_reg, overrun_flag_reg, full};
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_irq_line_a <= 1'b0;
         o_irq_line_b <= 1'b0;
      end else begin
         o_irq_line_a <= |(sources & irq_en_reg[3:0]);
         o_irq_line_b <= |(sources & irq_en_reg[7:4]);
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite write path
   // ----------------------------------------------------------------
   assign do_write = aw_held_reg && w_held_reg && !o_s_axi_bvalid;
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         aw_held_reg     <= 1'b0;
         w_held_reg      <= 1'b0;
         aw_addr_reg     <= 8'h00;
         w_data_reg      <= 32'h0000_0000;
         w_strb_reg      <= 4'h0;
         o_s_axi_awready <= 1'b1;
         o_s_axi_wready  <= 1'b1;
         o_s_axi_bvalid  <= 1'b0;
         o_s_axi_bresp   <= RESP_OKAY;
      end else begin
         if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_held_reg     <= 1'b1;
            aw_addr_reg     <= i_s_axi_awaddr;
            o_s_axi_awready <= 1'b0;
         end
         if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_held_reg     <= 1'b1;
            w_data_reg     <= i_s_axi_wdata;
            w_strb_reg     <= i_s_axi_wstrb;
            o_s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_held_reg    <= 1'b0;
            w_held_reg     <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp  <= is_mapped(aw_addr_reg) ? RESP_OKAY
                                                     : RESP_SLVERR;
         end
         if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_bvalid  <= 1'b0;
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         ctrl_reg       <= CTRL_RESET;
         irq_en_reg     <= 8'h00;
         sync_count_reg <= 8'h00;
      end else if (do_write && w_strb_reg[0]) begin
         case (aw_addr_reg)
            ADDR_CTRL: begin
               ctrl_reg[7:0] <= w_data_reg[7:0];
            end
            ADDR_IRQ_ENABLE: begin
               irq_en_reg <= w_data_reg[7:0];
            end
            ADDR_SYNC_COUNT: begin
               sync_count_reg <= w_data_reg[7:0];
            end
            default: begin
            end
         endcase
      end
      if (!i_reset && do_write && w_strb_reg[1] && aw_addr_reg == ADDR_CTRL)
      begin
         ctrl_reg[10:8] <= w_data_reg[10:8];
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read path
   // ----------------------------------------------------------------
   assign do_read = i_s_axi_arvalid;
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_s_axi_arready <= 1'b1;
         o_s_axi_rvalid  <= 1'b0;
         o_s_axi_rdata   <= 32'h0000_0000;
         o_s_axi_rresp   <= RESP_OKAY;
      end else if (i_s_axi_arvalid && o_s_axi_arready) begin
         o_s_axi_arready <= 1'b0;
         o_s_axi_rvalid  <= 1'b1;
         o_s_axi_rresp   <= is_mapped(i_s_axi_araddr) ? RESP_OKAY
                                                      : RESP_SLVERR;
         case (i_s_axi_araddr)
            ADDR_CTRL:       o_s_axi_rdata <= {21'h0, ctrl_reg};
            ADDR_IRQ_ENABLE: o_s_axi_rdata <= {24'h0, irq_en_reg};
            ADDR_SYNC_COUNT: o_s_axi_rdata <= {24'h0, sync_count_reg};
            ADDR_STATUS: begin
               o_s_axi_rdata <= {15'h0, count_reg, lock_reg, buf_enabled,
                                 gate_open, sync_active, sources};
            end
            ADDR_DATA_X:    o_s_axi_rdata <= {16'h0, data_reg[0]};
            ADDR_DATA_Y:    o_s_axi_rdata <= {16'h0, data_reg[1]};
            ADDR_DATA_Z:    o_s_axi_rdata <= {16'h0, data_reg[2]};
            ADDR_DATA_TEMP: o_s_axi_rdata <= {16'h0, data_reg[3]};
            ADDR_FIFO_XY: begin
               o_s_axi_rdata <= (mode == MODE_OFF || count_reg == '0)
                                ? 32'h0 : mem[rd_ptr_reg][31:0];
            end
            ADDR_FIFO_Z: begin
               o_s_axi_rdata <= (mode == MODE_OFF || count_reg == '0)
                                ? 32'h0
                                : {16'h0, mem[rd_ptr_reg][47:32]};
            end
            default:        o_s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
         o_s_axi_rvalid  <= 1'b0;
         o_s_axi_arready <= 1'b1;
      end
   end
endmodule

// >>> rate_fifo_monitor.sv
// port checker for the rate sample buffer
`timescale 1ns/1ps
module rate_fifo_monitor
   import rate_fifo_pkg::*;
(
   input wire logic        i_sys_clk, i_reset, i_low_power, o_wake_request,
   input wire logic        o_irq_line_a, o_irq_line_b,
   input wire logic        i_s_axi_awvalid, o_s_axi_awready,
   input wire logic        i_s_axi_wvalid, o_s_axi_wready, o_s_axi_bvalid,
   input wire logic        i_s_axi_arvalid, o_s_axi_arready,
   input wire logic        o_s_axi_rvalid, i_s_axi_rready,
   input wire logic [1:0]  o_s_axi_rresp,
   input wire logic [31:0] o_s_axi_rdata
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   sequence s_write_taken;
      i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
   endsequence
   sequence s_read_taken;
      i_s_axi_arvalid && o_s_axi_arready;
   endsequence
   a_write_answer: assert property (s_write_taken |-> ##2 o_s_axi_bvalid)
      else $error("write response missing");
   a_read_answer: assert property (s_read_taken |=> o_s_axi_rvalid)
      else $error("read data missing");
   a_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready
      |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
      else $error("read data dropped early");
   a_ar_blocked: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
      else $error("read address taken during answer");
   a_aw_blocked: assert property (o_s_axi_bvalid
      |-> !o_s_axi_awready && !o_s_axi_wready)
      else $error("write taken during response");
   a_slverr_zero: assert property (o_s_axi_rvalid
      && o_s_axi_rresp == RESP_SLVERR |-> o_s_axi_rdata == 32'h0)
      else $error("refused read returned data");
   a_wake_cause: assert property (
      o_wake_request |-> $past(i_low_power))
      else $error("wake request while awake");
   a_reset_idle: assert property ($fell(i_reset) |-> !o_s_axi_bvalid
      && !o_s_axi_rvalid && !o_irq_line_a && !o_irq_line_b)
      else $error("outputs busy after reset");
endmodule
bind rate_sample_fifo_sync rate_fifo_monitor rate_fifo_monitor_i (
   .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_low_power(i_low_power),
   .o_wake_request(o_wake_request), .o_irq_line_a(o_irq_line_a),
   .o_irq_line_b(o_irq_line_b), .i_s_axi_awvalid(i_s_axi_awvalid),
   .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wvalid(i_s_axi_wvalid),
   .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bvalid(o_s_axi_bvalid),
   .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
   .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
   .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rdata(o_s_axi_rdata));

// >>> host_model.sv
// host model: register bus master that reads sample sets
`timescale 1ns/1ps
module host_model
   import rate_fifo_pkg::*;
(
   input  wire logic        i_sys_clk,
   output logic [7:0]       o_awaddr, o_araddr,
   output logic [31:0]      o_wdata,
   output logic [3:0]       o_wstrb,
   output logic             o_awvalid, o_wvalid, o_bready,
   output logic             o_arvalid, o_rready,
   input  wire logic        i_awready, i_wready, i_bvalid, i_arready,
   input  wire logic        i_rvalid,
   input  wire logic [1:0]  i_bresp, i_rresp,
   input  wire logic [31:0] i_rdata
);
   initial begin
      {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h0;
      {o_awaddr, o_araddr, o_wdata, o_wstrb} = 52'h0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      bit aw_done = 0;
      bit w_done = 0;
      @(posedge i_sys_clk);
      o_awaddr <= a;
      o_wdata <= d;
      o_wstrb <= 4'hf;
      o_awvalid <= 1'b1;
      o_wvalid <= 1'b1;
      o_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge i_sys_clk);
         if (!aw_done && i_awready) begin
            aw_done = 1;
            o_awvalid <= 1'b0;
         end
         if (!w_done && i_wready) begin
            w_done = 1;
            o_wvalid <= 1'b0;
         end
      end
      do @(posedge i_sys_clk); while (!i_bvalid);
      r = i_bresp;
      o_bready <= 1'b0;
   endtask
   // slow holds rready low one cycle so the answer must wait
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r, input bit slow);
      @(posedge i_sys_clk);
      o_araddr <= a;
      o_arvalid <= 1'b1;
      do @(posedge i_sys_clk); while (!i_arready);
      o_arvalid <= 1'b0;
      if (slow) @(posedge i_sys_clk);
      o_rready <= 1'b1;
      do @(posedge i_sys_clk); while (!i_rvalid);
      d = i_rdata;
      r = i_rresp;
      o_rready <= 1'b0;
   endtask
   // each set read once, xy first, then z which pops it
   task automatic read_set(output logic [31:0] xy);
      logic [31:0] z;
      logic [1:0]  r;
      rd(ADDR_FIFO_XY, xy, r, 1'b0);
      rd(ADDR_FIFO_Z, z, r, 1'b0);
   endtask
endmodule

// >>> testbench.sv
// self-checking bench for the rate sample buffer
`timescale 1ns/1ps
module testbench;
   import rate_fifo_pkg::*;
   logic        i_sys_clk, i_reset, i_sample_valid, i_rate_irq, wake_seen;
   logic        i_sync_input_pin, i_low_power, o_wake_request;
   logic        o_irq_line_a, o_irq_line_b, awv, awr, wv, wr_rdy, bv, br;
   logic        arv, arr, rv, rr;
   logic [15:0] i_rate_x, i_rate_y, i_rate_z, i_temp;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rd_data, d;
   logic [3:0]  ws;
   logic [1:0]  bresp, rresp, r;
   int          error_cnt, samples_checked, cyc;
   rate_sample_fifo_sync rate_sample_fifo_sync_i (
      .i_sys_clk(i_sys_clk), .i_reset(i_reset),
      .i_sample_valid(i_sample_valid), .i_rate_x(i_rate_x),
      .i_rate_y(i_rate_y), .i_rate_z(i_rate_z), .i_temp(i_temp),
      .i_rate_irq(i_rate_irq), .i_sync_input_pin(i_sync_input_pin),
      .i_low_power(i_low_power), .o_wake_request(o_wake_request),
      .o_irq_line_a(o_irq_line_a), .o_irq_line_b(o_irq_line_b),
      .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
      .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws), .i_s_axi_wvalid(wv),
      .o_s_axi_wready(wr_rdy), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv),
      .i_s_axi_bready(br), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
      .o_s_axi_arready(arr), .o_s_axi_rdata(rd_data),
      .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr));
   host_model host_model_i (
      .i_sys_clk(i_sys_clk), .o_awaddr(awa), .o_araddr(ara), .o_wdata(wd),
      .o_wstrb(ws), .o_awvalid(awv), .o_wvalid(wv), .o_bready(br),
      .o_arvalid(arv), .o_rready(rr), .i_awready(awr), .i_wready(wr_rdy),
      .i_bvalid(bv), .i_arready(arr), .i_rvalid(rv), .i_bresp(bresp),
      .i_rresp(rresp), .i_rdata(rd_data));
   initial begin
      i_sys_clk = 0;
      forever #50 i_sys_clk = ~i_sys_clk;
   end
   // the whole run needs about 3300 cycles
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      wake_seen <= wake_seen | o_wake_request;
      if (cyc == 40000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic print_verdict;
      $display("mismatches %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic push(input logic [15:0] v);
      @(posedge i_sys_clk);
      i_sample_valid <= 1'b1;
      i_rate_x <= v;
      i_rate_y <= ~v;
      i_rate_z <= v + 16'h1;
      i_temp <= {v[7:0], v[15:8]};
      @(posedge i_sys_clk);
      i_sample_valid <= 1'b0;
   endtask
   task automatic pulse_irq;
      @(posedge i_sys_clk);
      i_rate_irq <= 1'b1;
      @(posedge i_sys_clk);
      i_rate_irq <= 1'b0;
   endtask
   // mode off in between flushes what earlier scenarios left behind,
   // and the sticky flags are cleared so each scenario sets its own
   task automatic set_mode(input logic [31:0] v);
      host_model_i.wr(ADDR_CTRL, 32'h700, r);
      host_model_i.wr(ADDR_STATUS, 32'hf, r);
      host_model_i.wr(ADDR_CTRL, v, r);
   endtask
   task automatic status_count(input logic [8:0] e);
      host_model_i.rd(ADDR_STATUS, d, r, 1'b0);
      chk("count", 32'(e), 32'(d[16:8]));
   endtask
   task automatic t_off;
      push(16'h1234);
      host_model_i.rd(ADDR_DATA_X, d, r, 1'b1);
      chk("data_x", 32'h1234, 32'(d[15:0]));
      host_model_i.rd(ADDR_DATA_TEMP, d, r, 1'b0);
      chk("temp", 32'h3412, 32'(d[15:0]));
      host_model_i.wr(ADDR_DATA_X, 32'h0, r);
      host_model_i.rd(ADDR_DATA_X, d, r, 1'b0);
      chk("data_x_ro", 32'h1234, 32'(d[15:0]));
      host_model_i.rd(ADDR_FIFO_XY, d, r, 1'b0);
      chk("off_fifo", 32'h0, d);
      host_model_i.rd(8'h40, d, r, 1'b1);
      chk("unmapped", 32'(RESP_SLVERR), 32'(r));
   endtask
   task automatic t_normal;
      host_model_i.wr(ADDR_IRQ_ENABLE, 32'h10, r);
      set_mode(32'h701);
      for (int i = 0; i < 257; i++) push(16'(i));
      status_count(9'd256);
      chk("full", 32'h1, 32'(d[ST_FULL]));
      chk("irq_b", 32'h1, 32'(o_irq_line_b));
      host_model_i.read_set(d);
      chk("first", 32'hffff0000, d);
      push(16'h55);
      status_count(9'd255);
      for (int i = 1; i < 256; i++) begin
         host_model_i.read_set(d);
         chk("order", 32'(i), 32'(d[15:0]));
      end
      push(16'h77);
      status_count(9'd1);
   endtask
   task automatic t_overwrite(input logic [31:0] mode, input bit trig);
      set_mode(mode);
      for (int i = 0; i < 258; i++) push(16'(i));
      if (trig) pulse_irq();
      if (trig) push(16'h99);
      status_count(9'd256);
      chk("lost", 32'h1, 32'(d[ST_OVERRUN]));
      host_model_i.read_set(d);
      chk("oldest", 32'h2, 32'(d[15:0]));
   endtask
   task automatic t_trigger;
      set_mode(32'h702);
      push(16'h1);
      status_count(9'd0);
      pulse_irq();
      push(16'h5);
      host_model_i.read_set(d);
      chk("armed", 32'h5, 32'(d[15:0]));
   endtask
   task automatic t_sync;
      host_model_i.wr(ADDR_SYNC_COUNT, 32'h2, r);
      host_model_i.wr(ADDR_IRQ_ENABLE, 32'h4, r);
      set_mode(32'h7e8);
      i_low_power <= 1'b1;
      push(16'h00a0);
      i_sync_input_pin <= 1'b1;
      push(16'h0010);
      push(16'h0020);
      push(16'h0030);
      host_model_i.rd(ADDR_DATA_X, d, r, 1'b0);
      chk("capture", 32'h21, 32'(d[15:0]));
      chk("wake", 32'h1, 32'(wake_seen));
      chk("irq_a", 32'h1, 32'(o_irq_line_a));
      host_model_i.wr(ADDR_STATUS, 32'h4, r);
      host_model_i.rd(ADDR_STATUS, d, r, 1'b0);
      chk("irq_a_clr", 32'h0, 32'(o_irq_line_a));
      host_model_i.wr(ADDR_CTRL, 32'h7f8, r);
      host_model_i.wr(ADDR_STATUS, 32'h4, r);
      host_model_i.rd(ADDR_STATUS, d, r, 1'b0);
      chk("level", 32'h1, 32'(d[ST_SYNC]));
   endtask
   initial begin
      {i_reset, i_sample_valid, i_rate_irq, wake_seen} = 4'h8;
      {i_sync_input_pin, i_low_power, i_rate_x, i_rate_y, i_rate_z} = 50'h0;
      i_temp = 16'h0;
      {error_cnt, samples_checked, cyc} = 96'h0;
      repeat (5) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      t_off();
      t_normal();
      t_overwrite(32'h705, 1'b0);
      t_overwrite(32'h703, 1'b1);
      t_trigger();
      t_sync();
      print_verdict();
   end
endmodule
